// >>> logic/btc_pkg.sv
// Operation
// RULE1: Each byte becomes one ten-bit character, shifted out one bit at a time.
// RULE2: Serial input bits are grouped by ten and data characters decoded to bytes.
// RULE3: Every byte value has a data character; spare codes act as special characters.
// RULE4: Label A is byte bit 0 up to H at bit 7; a..h follow A..H.
// RULE5: Bit i derives from A..E, bit j from F..H; groups abcdei and fghj.
// RULE6: Special flag high marks a special character, low an ordinary data byte.
// RULE7: Dxx.y naming: xx is bits E..A, y is bits H..F.
// RULE8: Byte 45 hex encodes to 101001 0101 from negative disparity.
// RULE9: Special characters reuse the nearest data sub-block encodings, e.g. K29.7.
// RULE10: Bits leave in order a b c d e i f g h j.
// RULE11: Disparity per sub-block: ones, balanced forced patterns, else unchanged; carries on.
// RULE12: Characters missing from the current column flag a violation yet still update disparity.
// RULE13: One character per character period; disparity is a single state bit.
// ****************************************************************
// Shared constants and coding functions
// ****************************************************************
package btc_pkg;

  localparam int unsigned CHAR_W    = 10;
  localparam logic [3:0]  BIT_LAST  = 4'h9;
  localparam logic [4:0]  K28_X     = 5'h1C;
  localparam logic [2:0]  K28_5_Y   = 3'h5;
  localparam logic [5:0]  K28_6B    = 6'h0F;
  localparam logic [3:0]  ALT7_4B   = 4'h7;
  localparam logic [5:0]  FORCE_P6  = 6'h07;
  localparam logic [5:0]  FORCE_N6  = 6'h38;
  localparam logic [3:0]  FORCE_P4  = 4'h3;
  localparam logic [3:0]  FORCE_N4  = 4'hC;
  localparam logic [9:0]  IDLE_CHAR = 10'h0FA;
  localparam logic        IDLE_RD   = 1'b1;

  // Negative-column six-bit codes, indexed by EDCBA, msb is a
  localparam logic [5:0] D6_TAB [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  // Negative-column four-bit codes, indexed by HGF, msb is f
  localparam logic [3:0] D4_TAB [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [3:0] K4_TAB [8] = '{
    4'hB, 4'h6, 4'hA, 4'hC, 4'hD, 4'h5, 4'h9, 4'h7};

  typedef struct packed {
    logic [9:0] tx_sh;
    logic [3:0] tx_cnt;
    logic       tx_rd;
    logic       tx_ready;
    logic [9:0] rx_sh;
    logic [3:0] rx_cnt;
    logic       rx_rd;
    logic [7:0] rx_data;
    logic       rx_k;
    logic       rx_viol;
    logic       rx_valid;
  } btc_state_s;

  localparam btc_state_s RESET_ST = '{tx_sh: IDLE_CHAR, tx_rd: IDLE_RD, default: '0};

  function automatic logic [2:0] btc_ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int b = 0; b < 6; b++) begin
      n = n + {2'h0, v[b]};
    end
    return n;
  endfunction : btc_ones

  // RULE11: six-bit disparity
  function automatic logic btc_rd6(input logic [5:0] s, input logic rd);
    logic [2:0] n;
    n = btc_ones(s);
    if (n > 3'h3 || s == FORCE_P6) return 1'b1;
    if (n < 3'h3 || s == FORCE_N6) return 1'b0;
    return rd;
  endfunction : btc_rd6

  // RULE11: four-bit disparity
  function automatic logic btc_rd4(input logic [3:0] f, input logic rd);
    logic [2:0] n;
    n = btc_ones({2'h0, f});
    if (n > 3'h2 || f == FORCE_P4) return 1'b1;
    if (n < 3'h2 || f == FORCE_N4) return 1'b0;
    return rd;
  endfunction : btc_rd4

  // RULE5: bit i from A..E, column picked by disparity
  function automatic logic [5:0] btc_enc6(input logic [4:0] x, input logic k,
                                          input logic rd);
    logic [5:0] r;
    r = (k && x == K28_X) ? K28_6B : D6_TAB[x];
    if (rd && (btc_ones(r) != 3'h3 || r == FORCE_N6)) r = ~r;
    return r;
  endfunction : btc_enc6

  // Alternate x.7 form avoids runs of five equal bits
  function automatic logic btc_alt7(input logic [4:0] x, input logic rd);
    if (rd) return (x == 5'h0B || x == 5'h0D || x == 5'h0E);
    return (x == 5'h11 || x == 5'h12 || x == 5'h14);
  endfunction : btc_alt7

  // RULE5: bit j from F..H; rd is disparity after the six-bit group
  function automatic logic [3:0] btc_enc4(input logic [2:0] y, input logic [4:0] x,
                                          input logic k, input logic rd);
    logic [3:0] t;
    // RULE9: special groups borrow data shapes
    t = k ? K4_TAB[y] : (y == 3'h7 && btc_alt7(x, rd)) ? ALT7_4B : D4_TAB[y];
    if (rd && (k || btc_ones({2'h0, t}) != 3'h2 || t == FORCE_N4)) t = ~t;
    return t;
  endfunction : btc_enc4

endpackage : btc_pkg

// >>> logic/btc_decode.sv
`timescale 1ns/100ps
// ****************************************************************
// Ten-bit character decoder, purely combinational
// ****************************************************************
module btc_decode
  import btc_pkg::*;
(
  // Received character and disparity before it
  input  wire logic [9:0] code_i,
  input  wire logic       rd_i,
  // Decoded result
  output logic [7:0]      data_o,
  output logic            special_o,
  output logic            viol_o,
  output logic            rd_o
);

  logic [5:0] s6;
  logic [3:0] f4;
  logic       rd6;
  logic       hit6;
  logic       hitd;
  logic       hitk;
  logic       k28;
  logic       kx7;
  logic [4:0] x;
  logic [2:0] y;
  logic [2:0] yk;

  // Search the column of the current disparity; tables stay single-sourced
  always_comb begin
    s6   = code_i[9:4];
    f4   = code_i[3:0];
    hit6 = 1'b0;
    hitd = 1'b0;
    hitk = 1'b0;
    x    = 5'h0;
    y    = 3'h0;
    yk   = 3'h0;
    // RULE11: carry into four-bit group
    rd6  = btc_rd6(s6, rd_i);
    // RULE12: disparity updates regardless
    rd_o = btc_rd4(f4, rd6);
    k28  = (s6 == btc_enc6(K28_X, 1'b1, rd_i));
    for (int v = 0; v < 32; v++) begin
      if (btc_enc6(5'(v), 1'b0, rd_i) == s6) begin
        hit6 = 1'b1;
        x    = 5'(v);
      end
    end
    for (int w = 0; w < 8; w++) begin
      if (!k28 && btc_enc4(3'(w), x, 1'b0, rd6) == f4) begin
        hitd = 1'b1;
        y    = 3'(w);
      end
      if (k28 && btc_enc4(3'(w), x, 1'b1, rd6) == f4) begin
        hitk = 1'b1;
        yk   = 3'(w);
      end
    end
    // RULE9: K23.7, K27.7, K29.7, K30.7
    kx7 = hit6 && (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E) &&
          f4 == btc_enc4(3'h7, x, 1'b1, rd6);
    // RULE6: special flag reported
    special_o = (k28 && hitk) || kx7;
    // RULE12: absent from column
    viol_o    = !(special_o || (hit6 && hitd));
    // RULE7: byte is {HGF, EDCBA}
    if (k28) begin
      data_o = {yk, K28_X};
    end else if (kx7) begin
      data_o = {3'h7, x};
    end else begin
      data_o = {y, x};
    end
  end

endmodule : btc_decode

// >>> logic/btc_codec.sv
`timescale 1ns/100ps
// ****************************************************************
// Byte to ten-bit character codec with serial shift
// ****************************************************************
module btc_codec
  import btc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       clk_en_i,
  // Transmit byte side
  input  wire logic [7:0] tx_data_i,
  input  wire logic       special_char_select_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic            tx_rd_o,
  // Serial link
  output logic            serial_o,
  input  wire logic       serial_i,
  // Receive byte side
  output logic [7:0]      rx_data_o,
  output logic            rx_special_char_select_o,
  output logic            rx_viol_o,
  output logic            rx_valid_o,
  output logic            rx_rd_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  btc_state_s st;
  btc_state_s next_st;

  logic [9:0] rx_word;
  logic [7:0] dec_data;
  logic       dec_k;
  logic       dec_viol;
  logic       dec_rd;

  // Word as it stands after this bit is taken
  assign rx_word = {st.rx_sh[8:0], serial_i};

  // RULE2: decode each complete group
  btc_decode u_dec (
    .code_i    (rx_word),
    .rd_i      (st.rx_rd),
    .data_o    (dec_data),
    .special_o (dec_k),
    .viol_o    (dec_viol),
    .rd_o      (dec_rd)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Encode, shift, gather; all work is paced by the bit counters
  always_comb begin
    logic [4:0] ex;
    logic [2:0] ey;
    logic       ek;
    logic       erd6;
    logic [5:0] e6;
    logic [3:0] e4;
    e6               = 6'h00;
    erd6             = 1'b0;
    e4               = 4'h0;
    next_st          = st;
    next_st.rx_valid = 1'b0;
    // RULE4: A is bit 0, H is bit 7
    ex   = tx_data_i[4:0];
    ey   = tx_data_i[7:5];
    // RULE6: flag selects special coding
    ek   = special_char_select_i;
    if (!tx_valid_i) begin
      // Idle comma keeps the far end's clock recovery fed
      ex = K28_X;
      ey = K28_5_Y;
      ek = 1'b1;
    end
    // RULE3: every byte maps; RULE8 falls out of the tables
    e6   = btc_enc6(ex, ek, st.tx_rd);
    // RULE11: disparity carries into fghj
    erd6 = btc_rd6(e6, st.tx_rd);
    e4   = btc_enc4(ey, ex, ek, erd6);
    if (st.tx_cnt == BIT_LAST) begin
      // RULE1: one character per ten bits
      next_st.tx_sh  = {e6, e4};
      // RULE13: single disparity bit
      next_st.tx_rd  = btc_rd4(e4, erd6);
      next_st.tx_cnt = 4'h0;
    end else begin
      // RULE10: msb first gives a..e, i, f..h, j
      next_st.tx_sh  = {st.tx_sh[8:0], 1'b0};
      next_st.tx_cnt = st.tx_cnt + 4'h1;
    end
    next_st.tx_ready = (next_st.tx_cnt == BIT_LAST);
    // RULE2: shift in serially, group by ten
    next_st.rx_sh = rx_word;
    if (st.rx_cnt == BIT_LAST) begin
      next_st.rx_cnt   = 4'h0;
      next_st.rx_data  = dec_data;
      next_st.rx_k     = dec_k;
      next_st.rx_viol  = dec_viol;
      next_st.rx_valid = 1'b1;
      // RULE12: update even on violation
      next_st.rx_rd    = dec_rd;
    end else begin
      next_st.rx_cnt = st.rx_cnt + 4'h1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Group boundary fixed from reset; no comma realignment here
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st <= RESET_ST;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign serial_o                 = st.tx_sh[CHAR_W-1];
  assign tx_ready_o               = st.tx_ready;
  assign tx_rd_o                  = st.tx_rd;
  assign rx_data_o                = st.rx_data;
  assign rx_special_char_select_o = st.rx_k;
  assign rx_viol_o                = st.rx_viol;
  assign rx_valid_o               = st.rx_valid;
  assign rx_rd_o                  = st.rx_rd;

endmodule : btc_codec

// >>> tb/btc_link_partner.sv
`timescale 1ns/100ps
// ****************
// Far end: loops the line back, can jam one group
// ****************
module btc_link_partner (
  // Line from and to the codec
  input  wire logic line_i,
  input  wire logic jam_i,
  output logic      line_o
);
  // bit order kept as sent
  // All-zero group is never a legal character
  assign line_o = jam_i ? 1'b0 : line_i;
endmodule : btc_link_partner

// >>> tb/btc_codec_checker.sv
`timescale 1ns/100ps
// ****************
// Codec port checker
// ****************
module btc_codec_checker (
  // Clock, reset, enable
  input wire logic       ref_clk_i,
  input wire logic       rst_b_i,
  input wire logic       clk_en_i,
  // Watched outputs
  input wire logic       tx_ready_o,
  input wire logic       tx_rd_o,
  input wire logic       serial_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       rx_valid_o,
  input wire logic       rx_rd_o
);
  logic [3:0] ph;
  // Bit phase; tracks the codec's bit counters, which reset to 0
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) ph <= 4'h0;
    else if (clk_en_i) ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Idle character loaded by reset, bit a first
  sequence idle_bits;
    !serial_o ##1 !serial_o ##1 serial_o [*5] ##1 !serial_o ##1 serial_o ##1 !serial_o;
  endsequence
  a_ready_phase: assert property (tx_ready_o == (ph == 4'h9))
    else $error("ready out of phase");
  a_valid_due: assert property (ph == 4'h9 && clk_en_i |=> rx_valid_o)
    else $error("group result missing");
  a_valid_phase: assert property (rx_valid_o |-> ph == 4'h0)
    else $error("result off group boundary");
  a_valid_pulse: assert property (rx_valid_o && clk_en_i |=> !rx_valid_o)
    else $error("result pulse too long");
  a_idle_order: assert property ($rose(rst_b_i) |-> idle_bits)
    else $error("idle bits out of order");
  a_txrd_hold: assert property (!(tx_ready_o && clk_en_i) |=> $stable(tx_rd_o))
    else $error("tx disparity moved between loads");
  a_rxrd_update: assert property ($changed(rx_rd_o) |-> rx_valid_o)
    else $error("rx disparity moved without a group");
  a_data_hold: assert property ($changed(rx_data_o) |-> rx_valid_o)
    else $error("rx byte moved without a group");
  a_stall_hold: assert property (!clk_en_i |=> $stable(serial_o) && $stable(tx_ready_o))
    else $error("line moved while stalled");
endmodule : btc_codec_checker

// >>> tb/btc_codec_test.sv
`timescale 1ns/100ps
// ****************
// Codec bench: loopback, stalls, jammed groups
// ****************
module btc_codec_test;
  logic       ref_clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       clk_en_i = 1'b1;
  logic [7:0] tx_data_i = 8'h00;
  logic       special_char_select_i = 1'b0;
  logic       tx_valid_i = 1'b0;
  logic       jam = 1'b0;
  logic       tx_ready_o, tx_rd_o, serial_o, serial_i;
  logic       rx_k, rx_viol, rx_valid_o, rx_rd_o;
  logic [7:0] rx_data_o;
  logic [9:0] stim [$];
  logic [8:0] sent [$];
  logic [9:0] tw, rw, nc;
  logic [8:0] ec;
  logic [7:0] ktab [12] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC, 8'hFC,
                            8'hF7, 8'hFB, 8'hFD, 8'hFE};
  logic [31:0] seed = 32'h0001_1C59;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          nw = 0;
  int          ns = 0;
  bit          trd, rrd, chk, ev, ecl;

  btc_codec btc_codec_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .tx_data_i(tx_data_i), .special_char_select_i(special_char_select_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_rd_o(tx_rd_o),
    .serial_o(serial_o), .serial_i(serial_i), .rx_data_o(rx_data_o),
    .rx_special_char_select_o(rx_k), .rx_viol_o(rx_viol), .rx_valid_o(rx_valid_o),
    .rx_rd_o(rx_rd_o));
  btc_link_partner btc_link_partner_i (.line_i(serial_o), .jam_i(jam), .line_o(serial_i));

  // Xorshift source, seed 72793
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Random offer: mostly data, some idles, some legal specials
  function automatic logic [9:0] rand_char();
    logic [31:0] r;
    r = xs();
    if (r[2:0] == 3'h0) return {2'b11, ktab[r[7:4] % 4'hC]};
    return {r[3] | r[4], 1'b0, r[15:8]};
  endfunction : rand_char

  function automatic bit rd_of(logic [9:0] w, bit rd);
    if ($countones(w[9:4]) != 3) rd = $countones(w[9:4]) > 3;
    else if (w[9:4] == 6'h07 || w[9:4] == 6'h38) rd = w[9:4] == 6'h07;
    if ($countones(w[3:0]) != 2) rd = $countones(w[3:0]) > 2;
    else if (w[3:0] == 4'h3 || w[3:0] == 4'hC) rd = w[3:0] == 4'h3;
    return rd;
  endfunction : rd_of

  task automatic cmp_val(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_val({9'h000, got}, {9'h000, exp});
  endtask : cmp_flag

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Clock, 25 ns period
  initial forever #12.5 ref_clk_i = ~ref_clk_i;

  // Directed list first: reference byte, every byte, every special
  initial begin
    sent.push_back(9'h1BC);
    stim.push_back(10'h245);
    for (int b = 0; b < 256; b++) stim.push_back({2'b10, b[7:0]});
    foreach (ktab[n]) stim.push_back({2'b11, ktab[n]});
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    wait (nw >= 280);
    $display("Directed characters done");
    wait (nw >= 600);
    $display("Random characters done");
    end_sim();
  end

  // Watchdog, about three times the expected run
  initial begin
    #600000;
    error_cnt++;
    $display("ERROR at %0t: words %h expected %h", $time, nw, 600);
    end_sim();
  end

  // Model: one step per enabled edge from the release edge on, which takes bit a
  always @(posedge ref_clk_i) begin
    if (rst_b_i) begin
      if (clk_en_i) begin
        if (rx_valid_o && chk) begin
          chk = 1'b0;
          cmp_flag(rx_rd_o, rrd);
          if (ecl) cmp_flag(rx_viol, ev);
          if (ecl && !ev) cmp_val({2'b00, rx_data_o}, {2'b00, ec[7:0]});
          if (ecl && !ev) cmp_flag(rx_k, ec[8]);
        end
        tw = {tw[8:0], serial_o};
        rw = {rw[8:0], serial_i};
        ns++;
        if (ns == 10) begin
          ns = 0;
          nw++;
          ec = sent.pop_front();
          ecl = jam || (rrd == trd);
          ev = jam;
          if (ec == 9'h045) cmp_val(tw, 10'h295);
          cmp_flag(trd ? ($countones(tw) inside {4, 5}) : ($countones(tw) inside {5, 6}), 1'b1);
          trd = rd_of(tw, trd);
          rrd = rd_of(rw, rrd);
          cmp_flag(tx_rd_o, trd);
          chk = 1'b1;
          jam <= (nw == 20 || nw == 300);
        end
        if (tx_ready_o) begin
          sent.push_back(tx_valid_i ? {special_char_select_i, tx_data_i} : 9'h1BC);
          nc = (stim.size() > 0) ? stim.pop_front() : rand_char();
          tx_valid_i <= nc[9];
          special_char_select_i <= nc[8];
          tx_data_i <= nc[7:0];
        end
      end
      clk_en_i <= (nw < 2) || (xs() % 4 != 0);
    end
  end
endmodule : btc_codec_test

bind btc_codec btc_codec_checker btc_codec_checker_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .clk_en_i(clk_en_i), .tx_ready_o(tx_ready_o), .tx_rd_o(tx_rd_o), .serial_o(serial_o),
  .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_rd_o(rx_rd_o));
